// [rtl/mpc_mode_priv.sv]
// Execution mode, privilege level and stack selection of the processor.
// Assumes instruction, exception and access strobes come from the same clock.
`timescale 1ns/10ps

module mpc_mode_priv
   import mpc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire mpc_instr_t instr_i,
   input wire logic exc_entry_i,
   input wire logic exc_return_i,
   input wire mpc_acc_t acc_i,
   input wire logic periph_lock_i,
   output logic handler_mode_o,
   output logic priv_o,
   output logic proc_stack_o,
   output logic [CTRL_W-1:0] ctrl_o,
   output logic [CTRL_W-1:0] ctrl_rdata_o,
   output logic instr_reject_o,
   output logic svc_req_o,
   output logic acc_deny_o
);

   // ****************************************************************
   // Mode and control state
   // ****************************************************************
   mpc_mode_t mode_reg;
   mpc_mode_t mode_next;
   logic [DEPTH_W-1:0] depth_reg;
   logic [DEPTH_W-1:0] depth_next;
   logic [CTRL_W-1:0] ctrl_reg;
   logic [CTRL_W-1:0] ctrl_next;
   logic priv_reg;
   logic priv_next;
   logic stack_reg;
   logic stack_next;
   logic cur_priv;

   always_comb begin
      depth_next = depth_reg;
      ctrl_next = ctrl_reg;
      if (exc_entry_i && !exc_return_i && depth_reg != DEPTH_MAX) begin
         depth_next = depth_reg + DEPTH_ONE;
      end else if (exc_return_i && !exc_entry_i && depth_reg != DEPTH_ZERO) begin
         depth_next = depth_reg - DEPTH_ONE;
      end
      // Back to thread only when the last nested exception is done
      case (depth_next == DEPTH_ZERO)
         1'b1: mode_next = MODE_THREAD;
         1'b0: mode_next = MODE_HANDLER;
         default: mode_next = MODE_THREAD;
      endcase
      if (instr_i.valid && instr_i.op == OP_MOVE_TO && instr_i.sel == SEL_CONTROL &&
          cur_priv) begin
         ctrl_next = instr_i.wdata;
      end
      // Handler is always privileged, thread follows the control bit
      priv_next = (mode_next == MODE_HANDLER) || !ctrl_next[CTRL_NPRIV_BIT];
      // Handler always on the main stack
      stack_next = (mode_next == MODE_THREAD) && ctrl_next[CTRL_SPSEL_BIT];
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_reg <= MODE_THREAD;
         depth_reg <= DEPTH_ZERO;
         ctrl_reg <= CTRL_RST;
         priv_reg <= 1'b1;
         stack_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         depth_reg <= depth_next;
         ctrl_reg <= ctrl_next;
         priv_reg <= priv_next;
         stack_reg <= stack_next;
      end
   end

   assign cur_priv = priv_reg;

   // ****************************************************************
   // Instruction permission
   // ****************************************************************
   logic reject_reg;
   logic reject_next;
   logic svc_reg;
   logic svc_next;
   logic [CTRL_W-1:0] rdata_reg;
   logic [CTRL_W-1:0] rdata_next;

   always_comb begin
      reject_next = 1'b0;
      svc_next = 1'b0;
      rdata_next = rdata_reg;
      if (instr_i.valid) begin
         case (instr_i.op)
            OP_MOVE_TO, OP_MOVE_FROM: begin
               reject_next = !cur_priv && !unpriv_sel_ok(instr_i.op, instr_i.sel);
               if (instr_i.op == OP_MOVE_FROM && instr_i.sel == SEL_CONTROL) begin
                  rdata_next = ctrl_reg;
               end
            end
            OP_STATE_CHANGE: reject_next = !cur_priv;
            OP_SUPV_CALL: svc_next = 1'b1;
            default: reject_next = 1'b0;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reject_reg <= 1'b0;
         svc_reg <= 1'b0;
         rdata_reg <= CTRL_RST;
      end else begin
         reject_reg <= reject_next;
         svc_reg <= svc_next;
         rdata_reg <= rdata_next;
      end
   end

   // ****************************************************************
   // Bus access check
   // ****************************************************************
   logic deny_comb;
   logic deny_reg;

   mpc_access_check u_access_check (
      .acc_i(acc_i),
      .priv_i(cur_priv),
      .periph_lock_i(periph_lock_i),
      .deny_o(deny_comb)
   );

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         deny_reg <= 1'b0;
      end else begin
         deny_reg <= deny_comb;
      end
   end

   assign handler_mode_o = mode_reg;
   assign priv_o = priv_reg;
   assign proc_stack_o = stack_reg;
   assign ctrl_o = ctrl_reg;
   assign ctrl_rdata_o = rdata_reg;
   assign instr_reject_o = reject_reg;
   assign svc_req_o = svc_reg;
   assign acc_deny_o = deny_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   reset_thread_a: assert property (disable iff (1'b0) $rose(arst_n_i) |->
      !handler_mode_o && !proc_stack_o)
      else $error("not in thread mode after reset");
   entry_handler_a: assert property (exc_entry_i && !exc_return_i |=> handler_mode_o)
      else $error("exception entry did not reach handler mode");
   nested_return_a: assert property (exc_return_i && !exc_entry_i && depth_reg > DEPTH_ONE
      |=> handler_mode_o)
      else $error("left handler mode with exceptions pending");
   state_change_a: assert property (instr_i.valid && instr_i.op == OP_STATE_CHANGE &&
      !priv_o |=> instr_reject_o)
      else $error("unprivileged state change not rejected");
   sys_deny_a: assert property (acc_i.valid && !priv_o &&
      in_window(acc_i.addr, SYS_CTRL_BASE, SYS_CTRL_LAST) |=> acc_deny_o)
      else $error("unprivileged system access not denied");
   priv_free_a: assert property (priv_o |=> !acc_deny_o && !instr_reject_o)
      else $error("privileged code restricted");
   thread_priv_a: assert property (!handler_mode_o |-> priv_o == !ctrl_o[CTRL_NPRIV_BIT])
      else $error("thread privilege does not follow control");
   handler_priv_a: assert property (handler_mode_o |-> priv_o && !proc_stack_o)
      else $error("handler mode not privileged on main stack");
   ctrl_guard_a: assert property (!priv_o && !exc_entry_i |=> $stable(ctrl_o))
      else $error("unprivileged write changed control");
   svc_req_a: assert property (instr_i.valid && instr_i.op == OP_SUPV_CALL
      |=> svc_req_o)
      else $error("supervisor call not raised");
   periph_lock_a: assert property (acc_i.valid && !priv_o && periph_lock_i &&
      in_window(acc_i.addr, PERIPH_BASE, PERIPH_LAST) |=> acc_deny_o)
      else $error("locked peripheral access not denied");
   open_access_a: assert property (acc_i.valid && !periph_lock_i &&
      !in_window(acc_i.addr, SYS_CTRL_BASE, SYS_CTRL_LAST) |=> !acc_deny_o)
      else $error("unlocked access denied");
   unpriv_write_a: assert property (instr_i.valid && instr_i.op == OP_MOVE_TO &&
      instr_i.sel == SEL_CONTROL && !priv_o |=> instr_reject_o)
      else $error("unprivileged control write not rejected");
   priv_write_a: assert property (instr_i.valid && instr_i.op == OP_MOVE_TO &&
      instr_i.sel == SEL_CONTROL && priv_o |=> ctrl_o == $past(instr_i.wdata))
      else $error("privileged control write lost");
   ctrl_read_a: assert property (instr_i.valid && instr_i.op == OP_MOVE_FROM &&
      instr_i.sel == SEL_CONTROL |=> ctrl_rdata_o == $past(ctrl_o))
      else $error("control read returned wrong value");
   thread_stack_a: assert property (!handler_mode_o |-> proc_stack_o == ctrl_o[CTRL_SPSEL_BIT])
      else $error("thread stack does not follow control");

   unpriv_svc_c: cover property (!priv_o ##1 svc_req_o ##[1:4] handler_mode_o);
   nested_c: cover property (depth_reg == 8'h02 ##[1:20] !handler_mode_o);
   deny_c: cover property (acc_deny_o ##1 instr_reject_o);
   drop_priv_c: cover property (!handler_mode_o && priv_o ##1 !priv_o);
   periph_c: cover property (periph_lock_i && acc_deny_o);

endmodule // mpc_mode_priv

// [rtl/mpc_pkg.sv]
// Constants, types and helpers shared by the mode and privilege control block.
// Assumes a single processor clock and an asynchronous active-low reset.
package mpc_pkg;

   // ****************************************************************
   // Exception nesting
   // ****************************************************************
   localparam int DEPTH_W = 8;
   localparam logic [DEPTH_W-1:0] DEPTH_ZERO = 8'h00;
   localparam logic [DEPTH_W-1:0] DEPTH_ONE = 8'h01;
   localparam logic [DEPTH_W-1:0] DEPTH_MAX = 8'hFF;

   // ****************************************************************
   // Mode control register
   // ****************************************************************
   localparam int CTRL_W = 2;
   localparam int CTRL_NPRIV_BIT = 0;
   localparam int CTRL_SPSEL_BIT = 1;
   localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

   // ****************************************************************
   // Special register selectors
   // ****************************************************************
   localparam logic [7:0] SEL_STATUS_LAST = 8'h07;
   localparam logic [7:0] SEL_MAIN_SP = 8'h08;
   localparam logic [7:0] SEL_PROC_SP = 8'h09;
   localparam logic [7:0] SEL_CONTROL = 8'h14;

   // ****************************************************************
   // Address windows
   // ****************************************************************
   localparam logic [31:0] SYS_CTRL_BASE = 32'hE000E000;
   localparam logic [31:0] SYS_CTRL_LAST = 32'hE000EFFF;
   localparam logic [31:0] PERIPH_BASE = 32'h40000000;
   localparam logic [31:0] PERIPH_LAST = 32'h5FFFFFFF;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_MOVE_TO = 3'h1,
      OP_MOVE_FROM = 3'h2,
      OP_STATE_CHANGE = 3'h3,
      OP_SUPV_CALL = 3'h4
   } mpc_op_t;

   typedef enum logic {
      MODE_THREAD = 1'b0,
      MODE_HANDLER = 1'b1
   } mpc_mode_t;

   typedef struct packed {
      logic valid;
      mpc_op_t op;
      logic [7:0] sel;
      logic [CTRL_W-1:0] wdata;
   } mpc_instr_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } mpc_acc_t;

   function automatic logic in_window(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
      in_window = (a >= lo) && (a <= hi);
   endfunction

   // Special registers that unprivileged code may move to or from
   function automatic logic unpriv_sel_ok(input mpc_op_t op, input logic [7:0] sel);
      unpriv_sel_ok = (sel <= SEL_STATUS_LAST) || (sel == SEL_PROC_SP) ||
                      ((op == OP_MOVE_FROM) && (sel == SEL_CONTROL));
   endfunction

endpackage

// [rtl/mpc_access_check.sv]
// Access permission check for one bus access at the current privilege level.
// Assumes address and privilege come from logic on the same clock.
`timescale 1ns/10ps
module mpc_access_check
   import mpc_pkg::*;
(
   input wire mpc_acc_t acc_i,
   input wire logic priv_i,
   input wire logic periph_lock_i,
   output logic deny_o
);

   logic sys_hit;
   logic periph_hit;

   always_comb begin
      sys_hit = in_window(acc_i.addr, SYS_CTRL_BASE, SYS_CTRL_LAST);
      periph_hit = in_window(acc_i.addr, PERIPH_BASE, PERIPH_LAST);
      deny_o = 1'b0;
      if (acc_i.valid && !priv_i) begin
         // Timer, interrupt controller and control block are privileged only
         // Optional lock of the peripheral window for unprivileged code
         deny_o = sys_hit || (periph_lock_i && periph_hit);
      end
      // Privileged accesses are never denied here
   end

endmodule // mpc_access_check

// [test/mpc_mode_priv_tb.sv]
// Self-checking bench for the mode and privilege control block.
// Assumes the package constants and the one-cycle answer of every output.
`timescale 1ns/10ps
module mpc_mode_priv_tb;
   import mpc_pkg::*;
   logic ref_clk_i;
   logic arst_n_i;
   mpc_instr_t instr_i;
   logic exc_entry_i;
   logic exc_return_i;
   mpc_acc_t acc_i;
   logic periph_lock_i;
   logic handler_mode_o, priv_o, proc_stack_o, instr_reject_o, svc_req_o, acc_deny_o;
   logic [CTRL_W-1:0] ctrl_o, ctrl_rdata_o, m_ctrl, m_rdata;
   logic [DEPTH_W-1:0] m_depth;
   logic [9:0] exp_q[$];
   logic [9:0] e, seen;
   logic [31:0] seed;
   logic [7:0] sels [7] = '{8'h00, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h14, 8'hFF};
   logic [31:0] accs [6] = '{32'hE000E000, 32'hE000EFFF, 32'hE000F000, 32'h40000000,
                             32'h5FFFFFFF, 32'h20000000};
   int n_errors, check_count, cycles;

   mpc_mode_priv dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .instr_i(instr_i),
      .exc_entry_i(exc_entry_i), .exc_return_i(exc_return_i), .acc_i(acc_i),
      .periph_lock_i(periph_lock_i), .handler_mode_o(handler_mode_o), .priv_o(priv_o),
      .proc_stack_o(proc_stack_o), .ctrl_o(ctrl_o), .ctrl_rdata_o(ctrl_rdata_o),
      .instr_reject_o(instr_reject_o), .svc_req_o(svc_req_o), .acc_deny_o(acc_deny_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ****************************************************************
   // Driver with reference model: notes the outputs due after the edge
   // ****************************************************************
   task automatic step(input mpc_op_t op, input logic [7:0] sel, input logic [1:0] wd,
                       input logic ent, input logic ret, input logic av,
                       input logic [31:0] a, input logic lock);
      logic p, ok, dny, h;
      @(negedge ref_clk_i);
      instr_i = {op != OP_NONE, op, sel, wd};
      exc_entry_i = ent;
      exc_return_i = ret;
      acc_i = {av, a};
      periph_lock_i = lock;
      p = (m_depth != DEPTH_ZERO) || !m_ctrl[CTRL_NPRIV_BIT];
      ok = p || op == OP_NONE || op == OP_SUPV_CALL || (op != OP_STATE_CHANGE &&
           (sel <= SEL_STATUS_LAST || sel == SEL_PROC_SP ||
           (op == OP_MOVE_FROM && sel == SEL_CONTROL)));
      dny = !p && av && ((a >= SYS_CTRL_BASE && a <= SYS_CTRL_LAST) ||
            (lock && a >= PERIPH_BASE && a <= PERIPH_LAST));
      if (ok && op == OP_MOVE_FROM && sel == SEL_CONTROL) m_rdata = m_ctrl;
      if (ok && op == OP_MOVE_TO && sel == SEL_CONTROL) m_ctrl = wd;
      if (ent && !ret && m_depth != DEPTH_MAX) m_depth = m_depth + DEPTH_ONE;
      else if (ret && !ent && m_depth != DEPTH_ZERO) m_depth = m_depth - DEPTH_ONE;
      h = m_depth != DEPTH_ZERO;
      exp_q.push_back({h, h || !m_ctrl[0], !h && m_ctrl[1], m_ctrl, m_rdata, !ok,
                       op == OP_SUPV_CALL, dny});
   endtask

   task automatic do_reset(input int n);
      @(negedge ref_clk_i);
      arst_n_i = 1'b0;
      instr_i = '0;
      exc_entry_i = 1'b0;
      exc_return_i = 1'b0;
      acc_i = '0;
      periph_lock_i = 1'b0;
      m_ctrl = CTRL_RST;
      m_rdata = 2'h0;
      m_depth = DEPTH_ZERO;
      repeat (n) @(negedge ref_clk_i);
      arst_n_i = 1'b1;
   endtask

   // ****************************************************************
   // Monitor and timeout
   // ****************************************************************
   initial begin
      forever begin
         @(posedge ref_clk_i);
         #5;
         cycles++;
         seen = {handler_mode_o, priv_o, proc_stack_o, ctrl_o, ctrl_rdata_o,
                 instr_reject_o, svc_req_o, acc_deny_o};
         if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check_count++;
            if (seen !== e) begin
               n_errors++;
               $display("ERROR outputs expected %b seen %b", e, seen);
            end
         end
         if (cycles > 5000) begin
            n_errors++;
            tally_and_finish();
         end
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      arst_n_i = 1'b0;
      seed = 32'h227A;
      do_reset(16);
      step(OP_NONE, 8'h00, 2'h0, 0, 0, 0, 32'h0, 0);
      for (int i = 1; i < 5; i++) step(mpc_op_t'(i), 8'h08, 2'h0, 0, 0, 1, accs[0], 1);
      step(OP_MOVE_FROM, 8'h14, 2'h0, 0, 0, 0, 32'h0, 0);
      step(OP_MOVE_TO, 8'h14, 2'h3, 0, 0, 0, 32'h0, 0);
      foreach (sels[i]) begin
         step(OP_MOVE_TO, sels[i], 2'h0, 0, 0, 0, 32'h0, 0);
         step(OP_MOVE_FROM, sels[i], 2'h0, 0, 0, 0, 32'h0, 0);
      end
      step(OP_STATE_CHANGE, 8'h00, 2'h0, 0, 0, 0, 32'h0, 0);
      for (int l = 0; l < 2; l++) begin
         foreach (accs[i]) step(OP_NONE, 8'h00, 2'h0, 0, 0, 1, accs[i], l[0]);
      end
      step(OP_SUPV_CALL, 8'h00, 2'h0, 0, 0, 0, 32'h0, 0);
      step(OP_NONE, 8'h00, 2'h0, 1, 0, 1, accs[0], 0);
      step(OP_NONE, 8'h00, 2'h0, 1, 0, 1, accs[0], 0);
      step(OP_MOVE_TO, 8'h14, 2'h2, 0, 1, 0, 32'h0, 0);
      step(OP_NONE, 8'h00, 2'h0, 0, 1, 0, 32'h0, 0);
      step(OP_NONE, 8'h00, 2'h0, 1, 1, 0, 32'h0, 0);
      step(OP_NONE, 8'h00, 2'h0, 0, 1, 0, 32'h0, 0);
      for (int k = 0; k < 400; k++) begin
         seed = xorshift(seed);
         step(mpc_op_t'(seed[2:0] % 3'h5), seed[3] ? sels[seed[6:4] % 3'h7] : seed[15:8],
              seed[17:16], seed[20:18] == 3'h0, seed[23:21] == 3'h0, seed[24],
              seed[25] ? accs[seed[28:26] % 3'h6] : seed, seed[31]);
      end
      do_reset(2);
      step(OP_NONE, 8'h00, 2'h0, 0, 0, 0, 32'h0, 0);
      @(posedge ref_clk_i);
      #10;
      tally_and_finish();
   end
endmodule // mpc_mode_priv_tb
